/* interp_mode_pkg.sv */
// package: register map, field layout, reset values and modes of the interpolation mode block
// Behaviour
// - eight-times interpolation emits eight output samples per input sample
// - each half-band stage runs at twice the rate of the previous stage
// - stage modes held in registers: 2-bit stage one, 6-bit stages two and three
// - 8x shift n: stage one n mod 4, two n mod 8, three n/2, doubled fields
// - 4x bypasses stage three; 2x bypasses stages two and three
// - stage-one mode 1 or 3 with premodulation adds half data rate shift
// - fine carrier oscillator applies remaining translation after coarse shifts
// - 32-bit tuning word; oscillator runs at twice data rate with stage one
// - new tuning word takes effect only on a 0-to-1 edge of update bit
// - four-times interpolation emits four output samples per input sample
package interp_mode_pkg;
	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STAGE_ONE   = 8'h1c;
	localparam logic [7:0] OFS_STAGE_TWO   = 8'h1d;
	localparam logic [7:0] OFS_STAGE_THREE = 8'h1e;
	localparam logic [7:0] OFS_TUNING_WORD = 8'h30;
	localparam logic [7:0] OFS_UPDATE      = 8'h36;
	localparam logic [7:0] OFS_CONTROL     = 8'h40;
	localparam logic [7:0] OFS_STATUS      = 8'h44;
	localparam logic [7:0] OFS_ACTIVE_WORD = 8'h48;
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CTL_FACTOR_LSB = 0;
	localparam int          CTL_PREMOD_BIT = 2;
	localparam int          CTL_ENABLE_BIT = 3;
	localparam int          UPD_BIT        = 0;
	localparam logic [1:0]  RST_STAGE_ONE  = 2'h0;
	localparam logic [5:0]  RST_STAGE_TWO  = 6'h00;
	localparam logic [5:0]  RST_STAGE_THREE = 6'h00;
	localparam logic [31:0] RST_TUNING_WORD = 32'h0000_0000;
	// interpolation factor codes
	typedef enum logic [1:0] {
		FACTOR_2X = 2'h0,
		FACTOR_4X = 2'h1,
		FACTOR_8X = 2'h3
	} factor_t;
	localparam factor_t RST_FACTOR = FACTOR_8X;
	// phase of the output sample sequencer
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h0,
		SEQ_RUN  = 2'h1,
		SEQ_LAST = 2'h3
	} seq_t;
endpackage : interp_mode_pkg

/* sample_fifo.sv */
// sample_fifo: small synchronous valid/ready fifo that buffers input sample words
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} fifo_state_t;
	fifo_state_t      s_q;
	fifo_state_t      s_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic             push;
	logic             pop;

	assign o_in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (s_q.cnt != '0);
	assign o_out_data  = mem_q[s_q.rd];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
		end
		if (pop) begin
			s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
		end
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// storage has no reset: contents are only read once counted valid
	always_ff @(posedge i_clk_sys) begin
		if (push) begin
			mem_q[s_q.wr] <= i_in_data;
		end
	end
endmodule // sample_fifo
`default_nettype wire

/* interp_mode_ctrl.sv */
// interp_mode_ctrl: apb mode registers, tuning word update and output-rate sequencer of the interpolation chain
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module interp_mode_ctrl #(
	parameter int SAMPLE_W   = 32,
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst,
	input  wire logic                i_psel,
	input  wire logic                i_penable,
	input  wire logic                i_pwrite,
	input  wire logic [7:0]          i_paddr,
	input  wire logic [31:0]         i_pwdata,
	output logic      [31:0]         o_prdata,
	output logic                     o_pready,
	output logic                     o_pslverr,
	input  wire logic                i_sample_valid,
	output logic                     o_sample_ready,
	input  wire logic [SAMPLE_W-1:0] i_sample_data,
	output logic                     o_out_valid,
	output logic      [SAMPLE_W-1:0] o_out_data,
	output logic      [2:0]          o_out_phase,
	output logic      [1:0]          o_halfband_stage_one,
	output logic      [5:0]          o_halfband_stage_two,
	output logic      [5:0]          o_halfband_stage_three,
	output logic                     o_stage_two_bypass,
	output logic                     o_stage_three_bypass,
	output logic                     o_premod_active,
	output logic      [31:0]         o_carrier_tuning_word,
	output logic                     o_nco_double_rate
);
	typedef struct packed {
		logic [1:0]                     stage_one;
		logic [5:0]                     stage_two;
		logic [5:0]                     stage_three;
		interp_mode_pkg::factor_t       factor;
		logic                           premod;
		logic                           enable;
		logic [31:0]                    word_pending;
		logic [31:0]                    word_active;
		logic                           update_q;
		interp_mode_pkg::seq_t          seq;
		logic [2:0]                     phase;
		logic                           out_valid;
		logic [SAMPLE_W-1:0]            out_data;
		logic [31:0]                    prdata;
		logic                           err;
	} ctrl_state_t;

	ctrl_state_t         s_q;
	ctrl_state_t         s_d;
	logic                fifo_valid;
	logic                fifo_take;
	logic [SAMPLE_W-1:0] fifo_data;
	logic                setup;
	logic                wr_en;
	logic                rd_en;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// a 6-bit stage field repeats its 3-bit mode in both halves
	function automatic logic [5:0] dup_mode(input logic [2:0] m);
		return {m, m};
	endfunction

	// number of output samples per input sample, minus one
	function automatic logic [2:0] last_phase(input interp_mode_pkg::factor_t f);
		case (f)
			interp_mode_pkg::FACTOR_2X: return 3'h1;
			interp_mode_pkg::FACTOR_4X: return 3'h3;
			interp_mode_pkg::FACTOR_8X: return 3'h7;
			default:                    return 3'h7;
		endcase
	endfunction

	function automatic logic known_addr(input logic [7:0] a);
		return a == interp_mode_pkg::OFS_STAGE_ONE || a == interp_mode_pkg::OFS_STAGE_TWO
			|| a == interp_mode_pkg::OFS_STAGE_THREE || a == interp_mode_pkg::OFS_TUNING_WORD
			|| a == interp_mode_pkg::OFS_UPDATE || a == interp_mode_pkg::OFS_CONTROL
			|| a == interp_mode_pkg::OFS_STATUS || a == interp_mode_pkg::OFS_ACTIVE_WORD;
	endfunction

	// ----------------------------------------------------------------
	// input buffer
	// ----------------------------------------------------------------
	sample_fifo #(
		.WIDTH (SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_rst       (i_rst),
		.i_in_valid  (i_sample_valid),
		.o_in_ready  (o_sample_ready),
		.i_in_data   (i_sample_data),
		.o_out_valid (fifo_valid),
		.i_out_ready (fifo_take),
		.o_out_data  (fifo_data)
	);

	// the sequencer takes a new word only after the last phase of the previous one,
	// so the fifo fills while the chain is busy producing output samples
	assign fifo_take = s_q.enable && fifo_valid
		&& (s_q.seq == interp_mode_pkg::SEQ_IDLE || s_q.seq == interp_mode_pkg::SEQ_LAST);

	// ----------------------------------------------------------------
	// apb slave: one wait-free access phase
	// ----------------------------------------------------------------
	assign setup     = i_psel && !i_penable;
	assign wr_en     = i_psel && i_penable && i_pwrite && known_addr(i_paddr);
	assign rd_en     = setup && !i_pwrite;
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel && i_penable && s_q.err;
	assign o_prdata  = s_q.prdata;

	always_comb begin
		s_d = s_q;
		// ---- bus decode ----
		if (setup) begin
			s_d.err = !known_addr(i_paddr);
		end
		if (rd_en) begin
			case (i_paddr)
				interp_mode_pkg::OFS_STAGE_ONE:   s_d.prdata = {30'h0, s_q.stage_one};
				interp_mode_pkg::OFS_STAGE_TWO:   s_d.prdata = {26'h0, s_q.stage_two};
				interp_mode_pkg::OFS_STAGE_THREE: s_d.prdata = {26'h0, s_q.stage_three};
				interp_mode_pkg::OFS_TUNING_WORD: s_d.prdata = s_q.word_pending;
				interp_mode_pkg::OFS_UPDATE:      s_d.prdata = {31'h0, s_q.update_q};
				interp_mode_pkg::OFS_CONTROL:     s_d.prdata = {28'h0, s_q.enable, s_q.premod, s_q.factor};
				interp_mode_pkg::OFS_STATUS:      s_d.prdata = {27'h0, s_q.phase, s_q.seq != interp_mode_pkg::SEQ_IDLE,
					fifo_valid};
				interp_mode_pkg::OFS_ACTIVE_WORD: s_d.prdata = s_q.word_active;
				default:                          s_d.prdata = 32'h0;
			endcase
		end
		if (wr_en) begin
			case (i_paddr)
				// mode fields are taken as written; software keeps them stable while streaming
				interp_mode_pkg::OFS_STAGE_ONE:   s_d.stage_one = i_pwdata[1:0];
				interp_mode_pkg::OFS_STAGE_TWO:   s_d.stage_two = i_pwdata[5:0];
				interp_mode_pkg::OFS_STAGE_THREE: s_d.stage_three = i_pwdata[5:0];
				interp_mode_pkg::OFS_TUNING_WORD: s_d.word_pending = i_pwdata;
				interp_mode_pkg::OFS_UPDATE: begin
					s_d.update_q = i_pwdata[interp_mode_pkg::UPD_BIT];
					// only a rising edge of the update bit moves the pending word into the oscillator
					if (i_pwdata[interp_mode_pkg::UPD_BIT] && !s_q.update_q) begin
						s_d.word_active = s_q.word_pending;
					end
				end
				interp_mode_pkg::OFS_CONTROL: begin
					s_d.factor = interp_mode_pkg::factor_t'(i_pwdata[interp_mode_pkg::CTL_FACTOR_LSB +: 2]);
					s_d.premod = i_pwdata[interp_mode_pkg::CTL_PREMOD_BIT];
					s_d.enable = i_pwdata[interp_mode_pkg::CTL_ENABLE_BIT];
				end
				default: ;
			endcase
		end
		// ---- output-rate sequencer ----
		s_d.out_valid = 1'b0;
		case (s_q.seq)
			interp_mode_pkg::SEQ_IDLE,
			interp_mode_pkg::SEQ_LAST: begin
				if (fifo_take) begin
					s_d.out_data  = fifo_data;
					s_d.out_valid = 1'b1;
					s_d.phase     = 3'h0;
					s_d.seq       = interp_mode_pkg::SEQ_RUN;
				end else begin
					s_d.seq = interp_mode_pkg::SEQ_IDLE;
				end
			end
			interp_mode_pkg::SEQ_RUN: begin
				// each stage doubles the rate, so a word yields 2, 4 or 8 output slots
				s_d.out_valid = 1'b1;
				s_d.phase     = s_q.phase + 3'h1;
				if (s_q.phase + 3'h1 == last_phase(s_q.factor)) begin
					s_d.seq = interp_mode_pkg::SEQ_LAST;
				end
			end
			default: s_d.seq = interp_mode_pkg::SEQ_IDLE;
		endcase
		if (!s_q.enable) begin
			s_d.seq = interp_mode_pkg::SEQ_IDLE;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			s_q              <= '0;
			s_q.stage_one    <= interp_mode_pkg::RST_STAGE_ONE;
			s_q.stage_two    <= interp_mode_pkg::RST_STAGE_TWO;
			s_q.stage_three  <= interp_mode_pkg::RST_STAGE_THREE;
			s_q.factor       <= interp_mode_pkg::RST_FACTOR;
			s_q.word_pending <= interp_mode_pkg::RST_TUNING_WORD;
			s_q.word_active  <= interp_mode_pkg::RST_TUNING_WORD;
			s_q.seq          <= interp_mode_pkg::SEQ_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// mode outputs to the filter chain
	// ----------------------------------------------------------------
	assign o_out_valid = s_q.out_valid;
	assign o_out_data  = s_q.out_data;
	assign o_out_phase = s_q.phase;
	assign o_halfband_stage_one = s_q.stage_one;
	// with 4x the third stage is bypassed, with 2x the second and third
	assign o_stage_two_bypass   = (s_q.factor == interp_mode_pkg::FACTOR_2X);
	// the spare factor code sequences eight slots, so it keeps all three stages in use
	assign o_stage_three_bypass = (s_q.factor == interp_mode_pkg::FACTOR_2X)
		|| (s_q.factor == interp_mode_pkg::FACTOR_4X);
	// bypassed fields are forced to zero so stale modes never reach an unused stage
	assign o_halfband_stage_two   = o_stage_two_bypass ? dup_mode(3'h0) : s_q.stage_two;
	assign o_halfband_stage_three = o_stage_three_bypass ? dup_mode(3'h0) : s_q.stage_three;
	// premodulation only has effect with odd stage-one modes
	assign o_premod_active = s_q.premod && s_q.stage_one[0];
	// fine oscillator word applies after the coarse shifts; stage one is always in use here
	assign o_carrier_tuning_word = s_q.word_active;
	assign o_nco_double_rate     = 1'b1;
endmodule // interp_mode_ctrl
`default_nettype wire

/* interp_mode_ctrl_chk.sv */
// checker: properties on the ports of the interpolation mode controller
`timescale 1ns/1ps
`default_nettype none
module interp_mode_ctrl_chk #(
	parameter int SAMPLE_W = 32
) (
	input wire logic                i_clk_sys,
	input wire logic                i_rst,
	input wire logic                i_psel,
	input wire logic                i_penable,
	input wire logic                i_pwrite,
	input wire logic [7:0]          i_paddr,
	input wire logic [31:0]         i_pwdata,
	input wire logic                o_pslverr,
	input wire logic                o_out_valid,
	input wire logic [SAMPLE_W-1:0] o_out_data,
	input wire logic [2:0]          o_out_phase,
	input wire logic [1:0]          o_halfband_stage_one,
	input wire logic [5:0]          o_halfband_stage_two,
	input wire logic [5:0]          o_halfband_stage_three,
	input wire logic                o_stage_two_bypass,
	input wire logic                o_stage_three_bypass,
	input wire logic                o_premod_active,
	input wire logic [31:0]         o_carrier_tuning_word
);
	// the active word may land one or two edges after the update write
	wire upd_wr = i_psel && i_penable && i_pwrite && i_paddr == interp_mode_pkg::OFS_UPDATE && i_pwdata[0];
	wire first  = o_out_valid && o_out_phase == 3'h0;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	eight_slots_a: assert property (first && !o_stage_three_bypass
		|-> ##7 (o_out_valid && o_out_phase == 3'h7)) else $error("8x slot run short");
	four_slots_a: assert property (first && o_stage_three_bypass && !o_stage_two_bypass
		|-> ##3 (o_out_valid && o_out_phase == 3'h3) ##1 (!o_out_valid || o_out_phase == 3'h0))
		else $error("4x slot run wrong");
	two_slots_a: assert property (first && o_stage_two_bypass
		|-> ##1 (o_out_valid && o_out_phase == 3'h1) ##1 (!o_out_valid || o_out_phase == 3'h0))
		else $error("2x slot run wrong");
	phase_step_a: assert property (o_out_valid && o_out_phase != 3'h0
		|-> $past(o_out_valid) && o_out_phase == $past(o_out_phase) + 3'h1) else $error("phase skipped");
	data_hold_a: assert property (o_out_valid && o_out_phase != 3'h0
		|-> $stable(o_out_data)) else $error("word changed in run");
	two_bypass_a: assert property (o_stage_two_bypass
		|-> o_stage_three_bypass && o_halfband_stage_two == 6'h00) else $error("stage two bypass");
	three_bypass_a: assert property (o_stage_three_bypass
		|-> o_halfband_stage_three == 6'h00) else $error("stage three bypass");
	premod_a: assert property (o_premod_active
		|-> o_halfband_stage_one[0]) else $error("premod with even mode");
	tuning_hold_a: assert property (!$stable(o_carrier_tuning_word)
		|-> $past(upd_wr) || $past(upd_wr, 2)) else $error("word moved without update");
	slverr_a: assert property (o_pslverr |-> i_psel && i_penable) else $error("stray slave error");
endmodule // interp_mode_ctrl_chk
bind interp_mode_ctrl interp_mode_ctrl_chk #(.SAMPLE_W(SAMPLE_W)) i_chk (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pslverr(o_pslverr), .o_out_valid(o_out_valid),
	.o_out_data(o_out_data), .o_out_phase(o_out_phase), .o_halfband_stage_one(o_halfband_stage_one),
	.o_halfband_stage_two(o_halfband_stage_two), .o_halfband_stage_three(o_halfband_stage_three),
	.o_stage_two_bypass(o_stage_two_bypass), .o_stage_three_bypass(o_stage_three_bypass),
	.o_premod_active(o_premod_active), .o_carrier_tuning_word(o_carrier_tuning_word));
`default_nettype wire

/* baseband_source.sv */
// partner model: baseband source handing sample words over, each held until taken
`timescale 1ns/1ps
`default_nettype none
module baseband_source (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_start,
	input  wire logic [3:0]  i_count,
	input  wire logic [31:0] i_base,
	input  wire logic        i_slow,
	input  wire logic        i_ready,
	output logic             o_valid,
	output logic      [31:0] o_data
);
	logic [3:0]  left_q;
	logic [31:0] word_q;
	logic        gap_q;
	// a slow source idles one cycle after each accepted word
	assign o_valid = left_q != 4'h0 && !gap_q;
	// idle lines show the inverse, never a stale copy that could pass by luck
	assign o_data = o_valid ? word_q : ~word_q;
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			left_q <= 4'h0;
			word_q <= 32'h0;
			gap_q  <= 1'b0;
		end else if (i_start) begin
			left_q <= i_count;
			word_q <= i_base;
			gap_q  <= 1'b0;
		end else if (o_valid && i_ready) begin
			left_q <= left_q - 4'h1;
			word_q <= word_q + 32'h1;
			gap_q  <= i_slow;
		end else begin
			gap_q <= 1'b0;
		end
	end
endmodule // baseband_source
`default_nettype wire

/* interpolation_filter_mode_select_test.sv */
// testbench: modes, output slots, fifo, tuning word and reset of the interpolation mode controller
`timescale 1ns/1ps
`default_nettype none
module interpolation_filter_mode_select_test;
	typedef struct {logic [1:0] code; int shifts; logic byp2; logic byp3; int slots;} row_t;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, base = 32'h0, rdata, prdata, out_data, tuning, s_data;
	logic [3:0] count = 4'h0;
	logic pready, pslverr, s_valid, s_ready, out_valid, byp2, byp3, premod, nco, rerr;
	logic [2:0] phase;
	logic [1:0] hb1;
	logic [5:0] hb2, hb3;
	int n_mismatch = 0, checks = 0, cycles = 0;
	logic [34:0] slots [$];
	row_t rows [3] = '{'{interp_mode_pkg::FACTOR_8X, 16, 1'b0, 1'b0, 8},
		'{interp_mode_pkg::FACTOR_4X, 8, 1'b0, 1'b1, 4}, '{interp_mode_pkg::FACTOR_2X, 4, 1'b1, 1'b1, 2}};
	always #2.5 i_clk_sys = ~i_clk_sys;
	interp_mode_ctrl #(.SAMPLE_W(32), .FIFO_DEPTH(4)) i_dut (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_sample_valid(s_valid), .o_sample_ready(s_ready), .i_sample_data(s_data), .o_out_valid(out_valid),
		.o_out_data(out_data), .o_out_phase(phase), .o_halfband_stage_one(hb1), .o_halfband_stage_two(hb2),
		.o_halfband_stage_three(hb3), .o_stage_two_bypass(byp2), .o_stage_three_bypass(byp3),
		.o_premod_active(premod), .o_carrier_tuning_word(tuning), .o_nco_double_rate(nco));
	baseband_source i_src (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(start), .i_count(count),
		.i_base(base), .i_slow(slow), .i_ready(s_ready), .o_valid(s_valid), .o_data(s_data));
	// -----------------------------
	// monitor and hang guard
	// -----------------------------
	always @(posedge i_clk_sys) begin
		cycles++;
		if (out_valid === 1'b1)
			slots.push_back({out_data, phase});
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk_sys);
		penable <= 1'b1;
		do @(posedge i_clk_sys); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		repeat (2) @(posedge i_clk_sys);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic launch(input logic [31:0] b, input logic [3:0] k, input logic sl);
		slots.delete();
		base <= b;
		count <= k;
		slow <= sl;
		start <= 1'b1;
		@(posedge i_clk_sys);
		start <= 1'b0;
	endtask
	task automatic collect(input logic [31:0] b, input int k, input int n);
		for (int w = 0; w < 400 && slots.size() < k * n; w++)
			@(posedge i_clk_sys);
		repeat (12) @(posedge i_clk_sys);
		cmp(slots.size(), k * n);
		for (int i = 0; i < slots.size(); i++)
			cmp(slots[i], {b + 32'(i / n), 3'(i % n)});
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// -----------------------------
	// main sequence
	// -----------------------------
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		foreach (rows[r])
			for (int n = 0; n < rows[r].shifts; n++) begin
				apb(1'b1, interp_mode_pkg::OFS_CONTROL, {29'h0, n[0], rows[r].code});
				apb(1'b1, interp_mode_pkg::OFS_STAGE_ONE, {30'h0, n[1:0]});
				apb(1'b1, interp_mode_pkg::OFS_STAGE_TWO, {26'h0, n[2:0], n[2:0]});
				apb(1'b1, interp_mode_pkg::OFS_STAGE_THREE, {26'h0, n[3:1], n[3:1]});
				rd(interp_mode_pkg::OFS_STAGE_TWO);
				cmp(rdata, {26'h0, n[2:0], n[2:0]});
				cmp(hb1, n[1:0]);
				cmp(hb2, rows[r].byp2 ? 6'h00 : {n[2:0], n[2:0]});
				cmp(hb3, rows[r].byp3 ? 6'h00 : {n[3:1], n[3:1]});
				cmp({byp2, byp3}, {rows[r].byp2, rows[r].byp3});
				cmp(premod, n[0]);
			end
		foreach (rows[r]) begin
			apb(1'b1, interp_mode_pkg::OFS_CONTROL, {28'h0, 2'b10, rows[r].code});
			launch(32'h0000_1000 << r, 4'h3, r[0]);
			collect(32'h0000_1000 << r, 3, rows[r].slots);
		end
		// disabled sequencer: four words fill the fifo and the fifth is refused
		apb(1'b1, interp_mode_pkg::OFS_CONTROL, 32'h0000_0003);
		launch(32'h0000_5000, 4'h5, 1'b0);
		repeat (12) @(posedge i_clk_sys);
		cmp(s_ready, 1'b0);
		rd(interp_mode_pkg::OFS_STATUS);
		cmp(rdata[0], 1'b1);
		apb(1'b1, interp_mode_pkg::OFS_CONTROL, 32'h0000_000b);
		collect(32'h0000_5000, 5, 8);
		// premodulation with an even stage-one mode has no effect
		apb(1'b1, interp_mode_pkg::OFS_STAGE_ONE, 32'h0000_0002);
		apb(1'b1, interp_mode_pkg::OFS_CONTROL, 32'h0000_0007);
		rd(interp_mode_pkg::OFS_CONTROL);
		cmp({premod, rdata[3:0]}, {1'b0, 4'h7});
		// spare factor code runs as eight-times with no stage bypassed
		apb(1'b1, interp_mode_pkg::OFS_CONTROL, 32'h0000_000a);
		launch(32'h0000_6000, 4'h1, 1'b0);
		collect(32'h0000_6000, 1, 8);
		cmp({byp2, byp3}, 2'b00);
		apb(1'b1, interp_mode_pkg::OFS_UPDATE, 32'h0);
		// a tenth of the oscillator rate
		apb(1'b1, interp_mode_pkg::OFS_TUNING_WORD, 32'h1999_9999);
		rd(interp_mode_pkg::OFS_ACTIVE_WORD);
		cmp(rdata, 32'h0);
		apb(1'b1, interp_mode_pkg::OFS_UPDATE, 32'h1);
		rd(interp_mode_pkg::OFS_ACTIVE_WORD);
		cmp({rdata, tuning, nco}, {32'h1999_9999, 32'h1999_9999, 1'b1});
		apb(1'b1, interp_mode_pkg::OFS_TUNING_WORD, 32'h0000_00ff);
		apb(1'b1, interp_mode_pkg::OFS_UPDATE, 32'h1);
		rd(interp_mode_pkg::OFS_ACTIVE_WORD);
		cmp(rdata, 32'h1999_9999);
		apb(1'b1, interp_mode_pkg::OFS_UPDATE, 32'h0);
		apb(1'b1, interp_mode_pkg::OFS_UPDATE, 32'h1);
		rd(interp_mode_pkg::OFS_ACTIVE_WORD);
		cmp(tuning, 32'h0000_00ff);
		rd(8'h50);
		cmp({rdata, rerr}, {32'h0, 1'b1});
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		cmp({hb1, hb2, hb3, byp2, byp3, tuning, s_ready, out_valid}, {48'h0, 2'b10});
		i_rst <= 1'b0;
		rd(interp_mode_pkg::OFS_CONTROL);
		cmp(rdata[1:0], interp_mode_pkg::RST_FACTOR);
		report_and_stop();
	end
endmodule // interpolation_filter_mode_select_test
`default_nettype wire
